// ### deser_output_strap_control.sv
/*
  Output-side control of a serial-video deserializer: strap sampling at power-up,
  working configuration with register override over APB, lock and self-test
  reporting, and the state of the parallel RGB, sync and pixel clock outputs.
  Assumes clock recovery delivers pixels with a one-cycle tick, at most every
  second clock, and that the pad ring resolves the output enables.
*/
`timescale 1ns/1ps
module deser_output_strap_control #(
  parameter int MIN_WIDTH = deser_out_pkg::FILTER_MIN_PIX,
  parameter int WINDOW    = deser_out_pkg::WINDOW_PIX
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        POWER_DOWN_N,
  input  wire logic        LOOP_LOCKED,
  input  wire logic        BIST_ENABLE,
  input  wire logic        RX_PIX_TICK,
  input  wire logic        RX_PAYLOAD_ERR,
  input  wire logic [23:0] RX_RGB,
  input  wire logic        RX_HSYNC,
  input  wire logic        RX_VSYNC,
  input  wire logic        RX_DE,
  input  wire logic [23:0] RGB_I,
  input  wire logic        PASS_I,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  output      logic [23:0] RGB_O,
  output      logic        RGB_OE,
  output      logic        HSYNC_O,
  output      logic        VSYNC_O,
  output      logic        DE_O,
  output      logic        PIX_CLK_O,
  output      logic        CTRL_OE,
  output      logic        LOCK_O,
  output      logic        PASS_O,
  output      logic        PASS_OE,
  output      logic [1:0]  MODE_O,
  output      logic [3:0]  EQ_O,
  output      logic [2:0]  OSC_O,
  output      logic [1:0]  MAP_O,
  output      logic [3:0]  SSC_O,
  output      logic        SPREAD_LOW_O,
  output      logic        DATA_SLEW_O,
  output      logic        PCLK_SLEW_O
);

  typedef struct packed {
    deser_out_pkg::pstate_t st;
    deser_out_pkg::cfg_t    cfg;
    logic                   unhold;
    logic                   lock;
    logic                   pass;
    logic                   spread_low;
    logic [23:0]            rgb;
    logic                   hs;
    logic                   vs;
    logic                   de;
    logic                   pclk;
    logic                   rgb_oe;
    logic                   ctl_oe;
    logic                   pass_oe;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } state_t;

  localparam state_t S_RESET = '{st: deser_out_pkg::ST_UNPOWERED, cfg: deser_out_pkg::CFG_RESET,
                                 unhold: deser_out_pkg::UNHOLD_RESET, pass: 1'b1, default: '0};

  state_t s_q;
  state_t s_d;

  logic       access;
  logic       wr_fire;
  logic       rate_clr;
  logic [1:0] out_sel;
  logic [2:0] ctrl_filt;
  logic [2:0] rate_err;

  // how the parallel outputs stand in the current state
  function automatic logic [1:0] out_mode(input state_t s);
    logic [1:0] m;
    m = deser_out_pkg::OUT_HIZ;
    case (s.st)
      deser_out_pkg::ST_UNPOWERED: m = deser_out_pkg::OUT_HIZ;
      deser_out_pkg::ST_SAMPLE:    m = deser_out_pkg::OUT_HIZ;
      deser_out_pkg::ST_DOWN: begin
        m = s.cfg.sleep_output_state_select ? deser_out_pkg::OUT_HIZ : deser_out_pkg::OUT_LOW;
      end
      deser_out_pkg::ST_RUN: begin
        if (s.cfg.hold_outputs_low && !s.unhold) begin
          m = deser_out_pkg::OUT_LOW;
        end else if (!s.lock) begin
          m = s.cfg.sleep_output_state_select ? deser_out_pkg::OUT_HIZ : deser_out_pkg::OUT_LOW;
        end else begin
          m = deser_out_pkg::OUT_LIVE;
        end
      end
      default: m = deser_out_pkg::OUT_HIZ;
    endcase
    return m;
  endfunction

  // straps on the shared pins into a working configuration
  function automatic deser_out_pkg::cfg_t strap_cfg(input logic [23:0] pins, input logic pass_pin);
    deser_out_pkg::cfg_t c;
    c                           = deser_out_pkg::CFG_RESET;
    c.mode                      = {pins[deser_out_pkg::PIN_MODE1], pins[deser_out_pkg::PIN_MODE0]};
    c.rx_equalization           = pins[deser_out_pkg::PIN_EQ_LSB +: 4];
    c.oscillator_select         = pins[deser_out_pkg::PIN_OSC_LSB +: 3];
    c.map_select                = pins[deser_out_pkg::PIN_MAP_LSB +: 2];
    c.spread_range              = pins[deser_out_pkg::PIN_SSC_LSB +: 4];
    c.spread_low_band           = pins[deser_out_pkg::PIN_LOW_BAND];
    c.data_slew_select          = pins[deser_out_pkg::PIN_DATA_SLEW];
    c.pixel_clock_slew_select   = pins[deser_out_pkg::PIN_PCLK_SLEW];
    c.sleep_output_state_select = pins[deser_out_pkg::PIN_SLEEP_SEL];
    c.strobe_edge_select        = pins[deser_out_pkg::PIN_EDGE_SEL];
    c.hold_outputs_low          = pass_pin;
    return c;
  endfunction

  assign access   = PSEL && PENABLE;
  assign wr_fire  = access && s_q.pready && PWRITE;
  assign rate_clr = wr_fire && (PADDR == deser_out_pkg::ADDR_STATUS);
  assign out_sel  = out_mode(s_q);

  ctrl_signal_guard #(
    .MIN_WIDTH (MIN_WIDTH),
    .WINDOW    (WINDOW)
  ) u_guard (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .tick      (RX_PIX_TICK),
    .filter_en (s_q.cfg.mode == deser_out_pkg::MODE_FILTER_ON),
    .ctrl_in   ({RX_VSYNC, RX_DE, RX_HSYNC}),
    .err_clr   (rate_clr),
    .ctrl_out  (ctrl_filt),
    .rate_err  (rate_err)
  );

  always_comb begin
    s_d = s_q;

    // apb: answer one cycle into the access phase
    s_d.pready  = access && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0;
    if (access && !s_q.pready) begin
      case (PADDR)
        deser_out_pkg::ADDR_CFG: begin
          s_d.prdata = 32'(s_q.cfg);
        end
        deser_out_pkg::ADDR_CTRL: begin
          s_d.prdata[deser_out_pkg::CTRL_UNHOLD_BIT] = s_q.unhold;
        end
        deser_out_pkg::ADDR_STATUS: begin
          s_d.prdata[deser_out_pkg::STAT_LOCK_BIT]           = s_q.lock;
          s_d.prdata[deser_out_pkg::STAT_PASS_BIT]           = s_q.pass;
          s_d.prdata[deser_out_pkg::STAT_BIST_BIT]           = BIST_ENABLE;
          s_d.prdata[deser_out_pkg::STAT_POWERED_BIT]        = (s_q.st == deser_out_pkg::ST_RUN);
          s_d.prdata[deser_out_pkg::STAT_RATE_LSB +: 3]      = rate_err;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_fire && s_q.st == deser_out_pkg::ST_RUN) begin
      case (PADDR)
        deser_out_pkg::ADDR_CFG: begin
          s_d.cfg = PWDATA[$bits(deser_out_pkg::cfg_t)-1:0];
        end
        deser_out_pkg::ADDR_CTRL: begin
          s_d.unhold = PWDATA[deser_out_pkg::CTRL_UNHOLD_BIT];
        end
        default: begin
        end
      endcase
    end

    // power sequencing
    case (s_q.st)
      deser_out_pkg::ST_UNPOWERED: begin
        if (POWER_DOWN_N) begin
          s_d.st = deser_out_pkg::ST_SAMPLE;
        end
      end
      deser_out_pkg::ST_SAMPLE: begin
        s_d.cfg = strap_cfg(RGB_I, PASS_I);
        s_d.st  = deser_out_pkg::ST_RUN;
      end
      deser_out_pkg::ST_RUN: begin
        s_d.st = deser_out_pkg::ST_RUN;
      end
      deser_out_pkg::ST_DOWN: begin
        if (POWER_DOWN_N) begin
          s_d.st = deser_out_pkg::ST_SAMPLE;
        end
      end
      default: begin
        s_d.st = deser_out_pkg::ST_UNPOWERED;
      end
    endcase
    if (!POWER_DOWN_N && s_q.st != deser_out_pkg::ST_UNPOWERED) begin
      s_d.st     = deser_out_pkg::ST_DOWN;
      s_d.cfg    = deser_out_pkg::CFG_RESET;
      s_d.unhold = deser_out_pkg::UNHOLD_RESET;
    end

    s_d.lock       = (s_q.st == deser_out_pkg::ST_RUN) && LOOP_LOCKED;
    s_d.spread_low = (s_q.cfg.spread_range != 4'h0) && s_q.cfg.spread_low_band;

    // self-test: pass drops on any payload error while running and stays down until self-test is disabled
    if (!BIST_ENABLE) begin
      s_d.pass = 1'b1;
    end else if (RX_PAYLOAD_ERR && s_q.st == deser_out_pkg::ST_RUN) begin
      s_d.pass = 1'b0;
    end
    s_d.pass_oe = (s_q.st == deser_out_pkg::ST_RUN) || (s_q.st == deser_out_pkg::ST_DOWN);

    // parallel outputs
    case (out_sel)
      deser_out_pkg::OUT_LIVE: begin
        s_d.rgb_oe = 1'b1;
        s_d.ctl_oe = 1'b1;
        if (RX_PIX_TICK) begin
          s_d.rgb  = RX_RGB;
          s_d.hs   = ctrl_filt[0];
          s_d.de   = ctrl_filt[1];
          s_d.vs   = ctrl_filt[2];
          s_d.pclk = !s_q.cfg.strobe_edge_select;
        end else begin
          s_d.pclk = s_q.cfg.strobe_edge_select;
        end
      end
      deser_out_pkg::OUT_LOW: begin
        s_d.rgb_oe = 1'b1;
        s_d.ctl_oe = 1'b1;
        s_d.rgb    = 24'h0;
        s_d.hs     = 1'b0;
        s_d.vs     = 1'b0;
        s_d.de     = 1'b0;
        s_d.pclk   = 1'b0;
      end
      default: begin
        s_d.rgb_oe = 1'b0;
        s_d.ctl_oe = 1'b0;
        s_d.rgb    = 24'h0;
        s_d.hs     = 1'b0;
        s_d.vs     = 1'b0;
        s_d.de     = 1'b0;
        s_d.pclk   = 1'b0;
      end
    endcase
    // straps are read next edge: release the shared pins first
    if (s_d.st == deser_out_pkg::ST_SAMPLE) begin
      s_d.rgb_oe  = 1'b0;
      s_d.ctl_oe  = 1'b0;
      s_d.pass_oe = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= S_RESET;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign PRDATA       = s_q.prdata;
  assign PREADY       = s_q.pready;
  assign PSLVERR      = s_q.pslverr;
  assign RGB_O        = s_q.rgb;
  assign RGB_OE       = s_q.rgb_oe;
  assign HSYNC_O      = s_q.hs;
  assign VSYNC_O      = s_q.vs;
  assign DE_O         = s_q.de;
  assign PIX_CLK_O    = s_q.pclk;
  assign CTRL_OE      = s_q.ctl_oe;
  assign LOCK_O       = s_q.lock;
  assign PASS_O       = s_q.pass;
  assign PASS_OE      = s_q.pass_oe;
  assign MODE_O       = s_q.cfg.mode;
  assign EQ_O         = s_q.cfg.rx_equalization;
  assign OSC_O        = s_q.cfg.oscillator_select;
  assign MAP_O        = s_q.cfg.map_select;
  assign SSC_O        = s_q.cfg.spread_range;
  assign SPREAD_LOW_O = s_q.spread_low;
  assign DATA_SLEW_O  = s_q.cfg.data_slew_select;
  assign PCLK_SLEW_O  = s_q.cfg.pixel_clock_slew_select;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_lock_high;
    (CE && s_q.st == deser_out_pkg::ST_RUN && LOOP_LOCKED) |=> LOCK_O;
  endproperty
  a_lock_high: assert property (p_lock_high) else $error("lock output missed a locked loop");

  property p_lock_low;
    (CE && !LOOP_LOCKED) |=> !LOCK_O;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock output high while unlocked");

  property p_pass_drop;
    (CE && BIST_ENABLE && RX_PAYLOAD_ERR && s_q.st == deser_out_pkg::ST_RUN) |=> !PASS_O;
  endproperty
  a_pass_drop: assert property (p_pass_drop) else $error("pass stayed high after an error");

  property p_unpowered_hiz;
    (s_q.st == deser_out_pkg::ST_UNPOWERED) |-> (!RGB_OE && !CTRL_OE && !PASS_OE);
  endproperty
  a_unpowered_hiz: assert property (p_unpowered_hiz) else $error("output driven before power-up");

  property p_hold_low;
    (CE && s_q.st == deser_out_pkg::ST_RUN && s_q.cfg.hold_outputs_low && !s_q.unhold)
      |=> (RGB_O == 24'h0 && !PIX_CLK_O && !DE_O && RGB_OE);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("outputs moved while held low");

  property p_powerdown_reset;
    (CE && !POWER_DOWN_N && s_q.st != deser_out_pkg::ST_UNPOWERED)
      |=> (s_q.st == deser_out_pkg::ST_DOWN && s_q.cfg == deser_out_pkg::CFG_RESET && !s_q.unhold);
  endproperty
  a_powerdown_reset: assert property (p_powerdown_reset) else $error("power-down kept control state");

  sequence s_launch;
    CE && RX_PIX_TICK && out_sel == deser_out_pkg::OUT_LIVE && !wr_fire && POWER_DOWN_N;
  endsequence
  property p_edge_launch;
    s_launch |=> (PIX_CLK_O != s_q.cfg.strobe_edge_select);
  endproperty
  a_edge_launch: assert property (p_edge_launch) else $error("pixel clock launch edge wrong");

  sequence s_sample;
    CE && s_q.st == deser_out_pkg::ST_SAMPLE && POWER_DOWN_N;
  endsequence
  property p_strap_sample;
    s_sample |=> (MODE_O == {$past(RGB_I[deser_out_pkg::PIN_MODE1]), $past(RGB_I[deser_out_pkg::PIN_MODE0])}
                  && EQ_O == $past(RGB_I[deser_out_pkg::PIN_EQ_LSB +: 4]));
  endproperty
  a_strap_sample: assert property (p_strap_sample) else $error("straps not sampled at power-up");

endmodule

// ### deser_out_pkg.sv
/*
  Shared constants and types of the deserializer output and strap control block:
  register offsets, field positions, strap pin positions, reset values and pixel counts.
  Assumes a 24-bit RGB bus packed as red [23:16], green [15:8], blue [7:0].
*/
// Functional notes
// - locked: lock output high, video outputs live
// - unlocked: lock low, outputs per sleep select
// - self-test pass high, low after payload error
// - vertical sync changes at most once/130 pixels
// - outputs launched against selected pixel clock edge
// - shared RGB pins inputs at power-up, then outputs
// - sample all straps once at power-up
// - mode 00/01 companion, filter off/on; 10/11 legacy
// - every strap setting overridable through config register
// - spread on: low band bit picks band
// - hold-low set: outputs low until released
// - hold-low clear: outputs toggle once locked
// - power-down: outputs per power-down and sleep select; cfg reset clears sleep select, so video outputs driven low
// - before power-up all outputs high impedance
// - slew selects default normal, one means increased
// - filter on: sync/enable pulses under 3 dropped
// - sync/enable at most two changes/130 pixels
// - edge select one rising, zero falling
// - power-down returns control registers to reset
package deser_out_pkg;

  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam int CTRL_UNHOLD_BIT  = 0;
  localparam int STAT_LOCK_BIT    = 0;
  localparam int STAT_PASS_BIT    = 1;
  localparam int STAT_BIST_BIT    = 2;
  localparam int STAT_POWERED_BIT = 3;
  localparam int STAT_RATE_LSB    = 4;

  // strap positions on the shared RGB pins
  localparam int PIN_MODE1     = 6;
  localparam int PIN_MODE0     = 7;
  localparam int PIN_EQ_LSB    = 12;
  localparam int PIN_OSC_LSB   = 8;
  localparam int PIN_MAP_LSB   = 16;
  localparam int PIN_SSC_LSB   = 19;
  localparam int PIN_LOW_BAND  = 4;
  localparam int PIN_DATA_SLEW = 3;
  localparam int PIN_PCLK_SLEW = 5;
  localparam int PIN_SLEEP_SEL = 2;
  localparam int PIN_EDGE_SEL  = 1;

  localparam logic [1:0] MODE_FILTER_OFF = 2'h0;
  localparam logic [1:0] MODE_FILTER_ON  = 2'h1;

  localparam logic [1:0] OUT_LIVE = 2'h0;
  localparam logic [1:0] OUT_LOW  = 2'h1;
  localparam logic [1:0] OUT_HIZ  = 2'h2;

  localparam int FILTER_MIN_PIX = 3;
  localparam int WINDOW_PIX     = 130;

  typedef struct packed {
    logic [3:0] spread_range;
    logic       strobe_edge_select;
    logic       sleep_output_state_select;
    logic       pixel_clock_slew_select;
    logic       data_slew_select;
    logic       hold_outputs_low;
    logic [1:0] map_select;
    logic       spread_low_band;
    logic [2:0] oscillator_select;
    logic [3:0] rx_equalization;
    logic [1:0] mode;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;
  localparam logic UNHOLD_RESET = 1'b0;

  typedef enum logic [1:0] {ST_UNPOWERED, ST_SAMPLE, ST_RUN, ST_DOWN} pstate_t;

endpackage

// ### ctrl_signal_guard.sv
/*
  Control-signal guard: minimum-width filter for horizontal sync and data enable,
  and transition-rate monitors for all three control signals (0 hs, 1 de, 2 vs).
  Assumes one pixel tick per recovered pixel, synchronous to the system clock.
*/
`timescale 1ns/1ps
module ctrl_signal_guard #(
  parameter int MIN_WIDTH = deser_out_pkg::FILTER_MIN_PIX,
  parameter int WINDOW    = deser_out_pkg::WINDOW_PIX
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       filter_en,
  input  wire logic [2:0] ctrl_in,
  input  wire logic       err_clr,
  output      logic [2:0] ctrl_out,
  output      logic [2:0] rate_err
);
  localparam logic [7:0] LIMIT   = 8'(WINDOW - 1);
  localparam logic [7:0] AGE_MAX = 8'hff;
  localparam logic [1:0] CNT_TOP = 2'(MIN_WIDTH - 1);

  typedef struct packed {
    logic [2:0]      filt;
    logic [1:0][1:0] cnt;
    logic [2:0][7:0] age1;
    logic [2:0][7:0] age2;
    logic [2:0]      last;
    logic [2:0]      err;
  } gstate_t;

  localparam gstate_t G_RESET = '{filt: 3'h0, cnt: '0, age1: {3{AGE_MAX}}, age2: {3{AGE_MAX}},
                                  last: 3'h0, err: 3'h0};

  gstate_t s_q;
  gstate_t s_d;

  always_comb begin
    s_d = s_q;
    if (err_clr) begin
      s_d.err = 3'h0;
    end
    if (tick) begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_in[i] != s_q.last[i]) begin
          if ((i == 2) ? (s_q.age1[i] < LIMIT) : (s_q.age2[i] < LIMIT)) begin
            s_d.err[i] = 1'b1;
          end
          s_d.age2[i] = (s_q.age1[i] == AGE_MAX) ? AGE_MAX : s_q.age1[i] + 8'h01;
          s_d.age1[i] = 8'h00;
        end else begin
          s_d.age1[i] = (s_q.age1[i] == AGE_MAX) ? AGE_MAX : s_q.age1[i] + 8'h01;
          s_d.age2[i] = (s_q.age2[i] == AGE_MAX) ? AGE_MAX : s_q.age2[i] + 8'h01;
        end
        s_d.last[i] = ctrl_in[i];
      end
      for (int i = 0; i < 2; i++) begin
        if (ctrl_in[i] == s_q.filt[i]) begin
          s_d.cnt[i] = 2'h0;
        end else if (s_q.cnt[i] == CNT_TOP) begin
          s_d.filt[i] = ctrl_in[i];
          s_d.cnt[i]  = 2'h0;
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 2'h1;
        end
      end
      s_d.filt[2] = ctrl_in[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= G_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // filter off: no minimum width, signals pass straight
  assign ctrl_out = filter_en ? {ctrl_in[2], s_q.filt[1:0]} : ctrl_in;
  assign rate_err = s_q.err;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_filter_hold;
    (ce && tick && filter_en && s_q.cnt[0] != CNT_TOP) |=> $stable(s_q.filt[0]);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("hsync filter passed a short pulse");

  property p_vs_rate;
    (ce && tick && ctrl_in[2] != s_q.last[2] && s_q.age1[2] < LIMIT) |=> s_q.err[2];
  endproperty
  a_vs_rate: assert property (p_vs_rate) else $error("fast vsync change not flagged");

  property p_hs_rate;
    (ce && tick && ctrl_in[0] != s_q.last[0] && s_q.age2[0] < LIMIT) |=> s_q.err[0];
  endproperty
  a_hs_rate: assert property (p_hs_rate) else $error("third hsync change not flagged");

endmodule

// ### link_source_model.sv
/*
  Serializer-side model: recovered pixels, sync, lock and payload errors.
  Assumes one clock shared with the block; slow halves the pixel rate.
*/
`timescale 1ns/1ps
module link_source_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        lock_req,
  input  wire logic        slow,
  input  wire logic        err_req,
  output      logic        locked,
  output      logic        tick,
  output      logic        perr,
  output      logic [23:0] rgb,
  output      logic        hs,
  output      logic        vs,
  output      logic        de
);
  logic [1:0] ph_q;
  logic [7:0] pix_q;
  logic [6:0] h_q;
  logic       nt;
  assign nt = slow ? (ph_q == 2'h3) : ph_q[0];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ph_q, pix_q, h_q, locked, tick, perr, rgb, hs, vs} <= '0;
      de <= 1'b1;
    end else begin
      ph_q <= ph_q + 2'h1;
      locked <= lock_req;
      tick <= nt;
      perr <= nt & err_req;
      // no hold once the pixel is taken
      rgb <= nt ? {pix_q, ~pix_q, pix_q ^ 8'h5a} : ~rgb;
      if (nt) begin
        pix_q <= pix_q + 8'h1;
        h_q <= (h_q == 7'd65) ? 7'd0 : h_q + 7'd1;
        if (h_q == 7'd65) begin
          hs <= ~hs;
          de <= hs;
          if (hs) vs <= ~vs;
        end
      end
    end
  end
endmodule

// ### tb.sv
/*
  Self-checking bench: straps, APB, lock, hold-low, self-test, power-down.
  Assumes link_source_model supplies pixels; APB notes checked by a watcher.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic err; logic rd; logic [31:0] dat;} note_t;
  logic clk = 0, rst = 1, power_down_n = 1, bist = 0, psel = 0, penable = 0, pwrite = 0;
  logic lock_req = 0, slow = 0, err_req = 0, vid_on = 0, t_q = 0, ce = 1, pass_i = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'd58, cfg_seen;
  logic [23:0] straps = '0, r_q = '0, rgb_o, rx_rgb;
  logic [3:0]  eq_o, ssc_o;
  logic [2:0]  osc_o, c_q = '0;
  logic [1:0]  mode_o, map_o;
  logic pready, pslverr, rgb_oe, hs_o, vs_o, de_o, pclk_o, ctrl_oe, lock_o, pass_o, pass_oe;
  logic slo, dsl, psl, locked, tick, perr, hs, vs, de;
  int   err_count = 0, checks_done = 0;
  note_t notes[$];
  note_t n_q;
  deser_out_pkg::cfg_t cfg_e;
  always #2 clk = ~clk;
  assign cfg_seen = 32'({mode_o, eq_o, osc_o, map_o, ssc_o, slo, dsl, psl});
  link_source_model lsm (.clk(clk), .rst(rst), .lock_req(lock_req), .slow(slow), .err_req(err_req),
    .locked(locked), .tick(tick), .perr(perr), .rgb(rx_rgb), .hs(hs), .vs(vs), .de(de));
  deser_output_strap_control DUT (.CLK(clk), .RST(rst), .CE(ce), .POWER_DOWN_N(power_down_n),
    .LOOP_LOCKED(locked), .BIST_ENABLE(bist), .RX_PIX_TICK(tick), .RX_PAYLOAD_ERR(perr),
    .RX_RGB(rx_rgb), .RX_HSYNC(hs), .RX_VSYNC(vs), .RX_DE(de), .RGB_I(straps), .PASS_I(pass_i),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RGB_O(rgb_o), .RGB_OE(rgb_oe),
    .HSYNC_O(hs_o), .VSYNC_O(vs_o), .DE_O(de_o), .PIX_CLK_O(pclk_o), .CTRL_OE(ctrl_oe),
    .LOCK_O(lock_o), .PASS_O(pass_o), .PASS_OE(pass_oe), .MODE_O(mode_o), .EQ_O(eq_o),
    .OSC_O(osc_o), .MAP_O(map_o), .SSC_O(ssc_o), .SPREAD_LOW_O(slo), .DATA_SLEW_O(dsl),
    .PCLK_SLEW_O(psl));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic deser_out_pkg::cfg_t from_straps(input logic [23:0] s);
    deser_out_pkg::cfg_t c;
    c = '0;
    c.mode = {s[6], s[7]};
    c.rx_equalization = s[15:12];
    c.oscillator_select = s[10:8];
    c.map_select = s[17:16];
    c.spread_range = s[22:19];
    c.spread_low_band = s[4];
    c.data_slew_select = s[3];
    c.pixel_clock_slew_select = s[5];
    c.sleep_output_state_select = s[2];
    c.strobe_edge_select = s[1];
    return c;
  endfunction
  function automatic logic [31:0] vec(input deser_out_pkg::cfg_t c);
    return 32'({c.mode, c.rx_equalization, c.oscillator_select, c.map_select, c.spread_range,
      (c.spread_range != 4'h0) & c.spread_low_band, c.data_slew_select, c.pixel_clock_slew_select});
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e,
                     input logic [31:0] x);
    int k;
    notes.push_back('{e, !wr, x});
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin err_count++; wrap_up(); end
  endtask
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) chk("apb_unexpected", 32'h1, 32'h0);
      else begin
        n_q = notes.pop_front();
        chk("pslverr", 32'(pslverr), 32'(n_q.err));
        if (n_q.rd) chk("prdata", prdata, n_q.dat);
      end
    end
    if (vid_on && t_q) begin
      chk("video", 32'(rgb_o), 32'(r_q));
      chk("pixclk", 32'(pclk_o), 32'(!cfg_e.strobe_edge_select));
      if (cfg_e.mode != deser_out_pkg::MODE_FILTER_ON) chk("sync", 32'({hs_o, vs_o, de_o}), 32'(c_q));
    end
    t_q = tick;
    r_q = rx_rgb;
    c_q = {hs, vs, de};
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    straps <= xs() & 24'hfcfffb;
    cyc(5);
    chk("oe_reset", 32'({rgb_oe, ctrl_oe, pass_oe, pass_o}), 32'h1);
    cyc(7);
    rst <= 1'b0;
    cyc(2);
    chk("oe_sample", 32'({rgb_oe, ctrl_oe, pass_oe}), 32'h0);
    cyc(4);
    cfg_e = from_straps(straps);
    chk("straps", cfg_seen, vec(cfg_e));
    straps <= xs() & 24'hfcfffb;
    cyc(4);
    chk("straps_kept", cfg_seen, vec(cfg_e));
    apb(1'b0, 8'h00, '0, 1'b0, 32'(cfg_e));
    apb(1'b0, 8'h0c, '0, 1'b1, '0);
    $display("test straps done");
    lock_req <= 1'b1;
    cyc(8);
    chk("lock_on", 32'({lock_o, rgb_oe, ctrl_oe}), 32'h7);
    vid_on <= 1'b1;
    cyc(40);
    vid_on <= 1'b0;
    lock_req <= 1'b0;
    cyc(6);
    chk("unlocked", 32'({lock_o, rgb_o, hs_o, vs_o, de_o, pclk_o, rgb_oe, ctrl_oe}), 32'h3);
    cfg_e.sleep_output_state_select = 1'b1;
    apb(1'b1, 8'h00, 32'(cfg_e), 1'b0, '0);
    cyc(3);
    chk("sleep_hiz", 32'({rgb_oe, ctrl_oe}), 32'h0);
    $display("test lock done");
    lock_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg_e = '0;
      cfg_e.mode = i[1:0];
      cfg_e.spread_low_band = i[0];
      cfg_e.spread_range = i[1] ? 4'h9 : 4'h0;
      apb(1'b1, 8'h00, 32'(cfg_e), 1'b0, '0);
      apb(1'b0, 8'h00, '0, 1'b0, 32'(cfg_e));
      chk("mode_cfg", cfg_seen, vec(cfg_e));
    end
    $display("test modes done");
    cfg_e = '0;
    cfg_e.hold_outputs_low = 1'b1;
    apb(1'b1, 8'h00, 32'(cfg_e), 1'b0, '0);
    slow <= 1'b1;
    repeat (6) begin cyc(3); chk("held_low", 32'(rgb_o), 32'h0); end
    apb(1'b1, 8'h04, 32'h1, 1'b0, '0);
    cyc(4);
    vid_on <= 1'b1;
    cyc(40);
    vid_on <= 1'b0;
    slow <= 1'b0;
    $display("test hold done");
    bist <= 1'b1;
    cyc(4);
    chk("pass_clean", 32'(pass_o), 32'h1);
    apb(1'b1, 8'h08, '0, 1'b0, '0);
    apb(1'b0, 8'h08, '0, 1'b0, 32'h0f);
    err_req <= 1'b1;
    cyc(6);
    err_req <= 1'b0;
    cyc(2);
    chk("pass_err", 32'(pass_o), 32'h0);
    apb(1'b0, 8'h08, '0, 1'b0, 32'h0d);
    bist <= 1'b0;
    cyc(3);
    chk("pass_off", 32'(pass_o), 32'h1);
    $display("test bist done");
    ce <= 1'b0;
    power_down_n <= 1'b0;
    cyc(4);
    chk("ce_freeze", 32'({lock_o, rgb_oe}), 32'h3);
    ce <= 1'b1;
    cyc(4);
    chk("pd_cfg", cfg_seen, 32'h0);
    chk("pd_out", 32'({rgb_o, pclk_o}), 32'h0);
    straps <= xs() & 24'hfcfffb;
    pass_i <= 1'b1;
    power_down_n <= 1'b1;
    cyc(2);
    chk("oe_resample", 32'({rgb_oe, ctrl_oe, pass_oe}), 32'h0);
    cyc(4);
    cfg_e = from_straps(straps);
    cfg_e.hold_outputs_low = 1'b1;
    chk("straps_again", cfg_seen, vec(cfg_e));
    chk("hold_strap", 32'({rgb_o, pclk_o, rgb_oe}), 32'h1);
    apb(1'b0, 8'h00, '0, 1'b0, 32'(cfg_e));
    apb(1'b0, 8'h04, '0, 1'b0, 32'h0);
    cyc(3);
    $display("test power_down done");
    wrap_up();
  end
endmodule
